/* File: instr_decode_defines.vh */
// Constants for the instruction word decoder and cycle sequencer
`ifndef INSTR_DECODE_DEFINES_VH
`define INSTR_DECODE_DEFINES_VH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define IW_WIDTH        14
`define IW_CLASS_HI     13
`define IW_CLASS_LO     12
`define IW_DEST_BIT     7
`define IW_FILE_HI      6
`define IW_FILE_LO      0
`define IW_BPOS_HI      9
`define IW_BPOS_LO      7
`define IW_LIT8_HI      7
`define IW_LIT11_HI     10

// ----------------------------------------------------------------
// Instruction classes (top two bits)
// ----------------------------------------------------------------
`define CLS_BYTE        2'h0
`define CLS_BIT         2'h1
`define CLS_JUMP        2'h2
`define CLS_LIT         2'h3

// ----------------------------------------------------------------
// Byte-class operation codes (bits 11:8)
// ----------------------------------------------------------------
`define OP_MOVWF        4'h0
`define OP_CLR          4'h1
`define OP_SUBWF        4'h2
`define OP_DECF         4'h3
`define OP_IORWF        4'h4
`define OP_ANDWF        4'h5
`define OP_XORWF        4'h6
`define OP_ADDWF        4'h7
`define OP_MOVF         4'h8
`define OP_COMF         4'h9
`define OP_INCF         4'hA
`define OP_DECFSZ       4'hB
`define OP_RRF          4'hC
`define OP_RLF          4'hD
`define OP_SWAPF        4'hE
`define OP_INCFSZ       4'hF

// ----------------------------------------------------------------
// Bit-class operation codes (bits 11:10)
// ----------------------------------------------------------------
`define BOP_CLEAR       2'h0
`define BOP_SET         2'h1
`define BOP_SKIP_CLR    2'h2
`define BOP_SKIP_SET    2'h3

// ----------------------------------------------------------------
// Control words and timing
// ----------------------------------------------------------------
`define W_RETURN        14'h0008
`define W_RETFIE        14'h0009
`define W_NOP           14'h0000
`define LIT_RETLW       2'h1
`define PHASES_PER_CYC  4
`define PHASE_W         2
`define PHASE_READ      2'h1
`define PHASE_WRITE     2'h3
`define TIMER_ZERO_ADDR 7'h01

`endif

/* File: phase_counter.v */
// Oscillator phase counter producing four phases per instruction cycle
`timescale 1ns/1ps
`include "instr_decode_defines.vh"

module phase_counter (
  // Clock and reset
  input  wire                 clk_i,
  input  wire                 rst_n_i,
  // Phase outputs
  output reg  [`PHASE_W-1:0]  phase_o,
  output wire                 cycle_end_o
);

  assign cycle_end_o = (phase_o == `PHASE_WRITE);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_o <= {`PHASE_W{1'b0}};
    end else begin
      phase_o <= phase_o + 2'h1;
    end
  end

endmodule // phase_counter

/* File: field_extract.v */
// Operand field extraction from one instruction word
`timescale 1ns/1ps
`include "instr_decode_defines.vh"

module field_extract (
  // Instruction word
  input  wire [`IW_WIDTH-1:0] word_i,
  // Fields
  output wire [1:0]           iclass_o,
  output wire [3:0]           byte_op_o,
  output wire [1:0]           bit_op_o,
  output wire [6:0]           file_sel_o,
  output wire                 dest_reg_o,
  output wire [2:0]           bit_pos_o,
  output wire [7:0]           lit8_o,
  output wire [10:0]          lit11_o
);

  assign iclass_o   = word_i[`IW_CLASS_HI:`IW_CLASS_LO];
  assign byte_op_o  = word_i[11:8];
  assign bit_op_o   = word_i[11:10];
  assign file_sel_o = word_i[`IW_FILE_HI:`IW_FILE_LO];
  assign dest_reg_o = word_i[`IW_DEST_BIT];
  assign bit_pos_o  = word_i[`IW_BPOS_HI:`IW_BPOS_LO];
  assign lit8_o     = word_i[`IW_LIT8_HI:0];
  assign lit11_o    = word_i[`IW_LIT11_HI:0];

endmodule // field_extract

/* File: instr_word_decode_timing.v */
// Instruction decoder with read-modify-write sequencing and cycle timing
`timescale 1ns/1ps
`include "instr_decode_defines.vh"

module instr_word_decode_timing #(
  parameter FILE_AW = 7
) (
  // Clock and reset
  input  wire                 sys_clk_i,
  input  wire                 arst_n_i,
  // Fetch side
  input  wire [`IW_WIDTH-1:0] fetch_word_i,
  output wire                 fetch_take_o,
  // Register file side
  input  wire [7:0]           file_rdata_i,
  input  wire                 file_is_port_i,
  input  wire [7:0]           port_pins_i,
  input  wire                 prescaler_on_timer_i,
  input  wire [7:0]           acc_i,
  input  wire                 carry_i,
  output reg  [FILE_AW-1:0]   file_addr_o,
  output reg                  file_rd_o,
  output reg                  file_wr_o,
  output reg  [7:0]           file_wdata_o,
  output reg                  acc_wr_o,
  output reg  [7:0]           acc_wdata_o,
  output reg                  prescaler_clr_o,
  // Program flow
  output reg                  pc_load_o,
  output reg  [10:0]          pc_target_o,
  output reg                  pc_return_o,
  output reg                  lit_valid_o,
  output reg  [10:0]          lit_o,
  output reg                  flush_cycle_o,
  output reg                  retire_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_meta;
  reg rst_sync;

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  wire [`PHASE_W-1:0] phase;
  wire                cycle_end;

  phase_counter u_phase (
    .clk_i       (sys_clk_i),
    .rst_n_i     (rst_sync),
    .phase_o     (phase),
    .cycle_end_o (cycle_end)
  );

  // ----------------------------------------------------------------
  // Instruction latch
  // ----------------------------------------------------------------
  reg [`IW_WIDTH-1:0] cur_word;
  reg                 flushing;
  reg                 next_flushing;

  // Fetch is taken once per cycle, at its last phase
  assign fetch_take_o = cycle_end;

  always @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      cur_word <= `W_NOP;
      flushing <= 1'b1;
    end else if (cycle_end) begin
      // On a flush the fetched word is discarded, a no-op runs instead
      cur_word <= next_flushing ? `W_NOP : fetch_word_i;
      flushing <= next_flushing;
    end
  end

  wire [1:0]  iclass;
  wire [3:0]  byte_op;
  wire [1:0]  bit_op;
  wire [6:0]  file_sel;
  wire        dest_reg;
  wire [2:0]  bit_pos;
  wire [7:0]  lit8;
  wire [10:0] lit11;

  field_extract u_fields (
    .word_i     (cur_word),
    .iclass_o   (iclass),
    .byte_op_o  (byte_op),
    .bit_op_o   (bit_op),
    .file_sel_o (file_sel),
    .dest_reg_o (dest_reg),
    .bit_pos_o  (bit_pos),
    .lit8_o     (lit8),
    .lit11_o    (lit11)
  );

  // ----------------------------------------------------------------
  // Operand classification
  // ----------------------------------------------------------------
  // Control words use only exact low patterns; other byte-0 words
  // with d=0 (x bits) are no-ops, so don't-care bits stay inert
  wire is_ctrl    = (iclass == `CLS_BYTE) && (byte_op == `OP_MOVWF) &&
                    !dest_reg;
  wire is_return  = (cur_word == `W_RETURN) || (cur_word == `W_RETFIE);
  wire is_retlw   = (iclass == `CLS_LIT) && (cur_word[11:10] == `LIT_RETLW);
  wire is_jump    = (iclass == `CLS_JUMP);
  wire clr_acc    = (iclass == `CLS_BYTE) && (byte_op == `OP_CLR) &&
                    !dest_reg;
  // Every instruction naming a register, pure writes included
  wire uses_file  = ((iclass == `CLS_BYTE) && !is_ctrl && !clr_acc) ||
                    (iclass == `CLS_BIT);

  // ----------------------------------------------------------------
  // Operand capture
  // ----------------------------------------------------------------
  reg [7:0] operand;

  always @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      operand <= 8'h00;
    end else if (phase == `PHASE_READ && uses_file && !flushing) begin
      // Ports modified from themselves use pin levels, not latches
      operand <= file_is_port_i ? port_pins_i : file_rdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Modify
  // ----------------------------------------------------------------
  reg [7:0] result;
  reg       to_file;
  reg       skip;
  reg [7:0] bit_mask;

  always @* begin
    result   = operand;
    to_file  = dest_reg;
    skip     = 1'b0;
    bit_mask = 8'h01 << bit_pos;
    case (iclass)
      `CLS_BYTE: begin
        case (byte_op)
          `OP_MOVWF:  begin result = acc_i; to_file = 1'b1; end
          `OP_CLR:    result = 8'h00;
          `OP_SUBWF:  result = operand - acc_i;
          `OP_DECF:   result = operand - 8'h01;
          `OP_IORWF:  result = operand | acc_i;
          `OP_ANDWF:  result = operand & acc_i;
          `OP_XORWF:  result = operand ^ acc_i;
          `OP_ADDWF:  result = operand + acc_i;
          `OP_MOVF:   result = operand;
          `OP_COMF:   result = ~operand;
          `OP_INCF:   result = operand + 8'h01;
          `OP_DECFSZ: begin
            result = operand - 8'h01;
            skip   = (result == 8'h00);
          end
          `OP_RRF:    result = {carry_i, operand[7:1]};
          `OP_RLF:    result = {operand[6:0], carry_i};
          `OP_SWAPF:  result = {operand[3:0], operand[7:4]};
          `OP_INCFSZ: begin
            result = operand + 8'h01;
            skip   = (result == 8'h00);
          end
          default:    result = operand;
        endcase
      end
      `CLS_BIT: begin
        to_file = 1'b1;
        case (bit_op)
          `BOP_CLEAR:    result = operand & ~bit_mask;
          `BOP_SET:      result = operand | bit_mask;
          `BOP_SKIP_CLR: begin
            to_file = 1'b0;
            skip    = ((operand & bit_mask) == 8'h00);
          end
          `BOP_SKIP_SET: begin
            to_file = 1'b0;
            skip    = ((operand & bit_mask) != 8'h00);
          end
          default:       to_file = 1'b0;
        endcase
      end
      default: begin
        to_file = 1'b0;
      end
    endcase
  end

  // Skip tests never store, except increment/decrement forms
  wire test_only = (iclass == `CLS_BIT) && bit_op[1];
  wire writes_file = uses_file && to_file && !flushing;
  wire writes_acc  = !flushing &&
                     ((uses_file && !to_file && !test_only) || clr_acc ||
                      ((iclass == `CLS_LIT) && !is_retlw) || is_retlw);

  // Next cycle is a flush when flow changes or a test succeeds
  always @* begin
    next_flushing = !flushing &&
                    (is_jump || is_return || is_retlw ||
                     (uses_file && skip));
  end

  // ----------------------------------------------------------------
  // Store and strobes
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      file_addr_o     <= {FILE_AW{1'b0}};
      file_rd_o       <= 1'b0;
      file_wr_o       <= 1'b0;
      file_wdata_o    <= 8'h00;
      acc_wr_o        <= 1'b0;
      acc_wdata_o     <= 8'h00;
      prescaler_clr_o <= 1'b0;
      pc_load_o       <= 1'b0;
      pc_target_o     <= 11'h000;
      pc_return_o     <= 1'b0;
      lit_valid_o     <= 1'b0;
      lit_o           <= 11'h000;
      flush_cycle_o   <= 1'b0;
      retire_o        <= 1'b0;
    end else begin
      file_addr_o     <= file_sel[FILE_AW-1:0];
      file_rd_o       <= (phase == `PHASE_READ - 2'h1) && uses_file &&
                         !flushing;
      file_wr_o       <= 1'b0;
      acc_wr_o        <= 1'b0;
      prescaler_clr_o <= 1'b0;
      pc_load_o       <= 1'b0;
      pc_return_o     <= 1'b0;
      lit_valid_o     <= 1'b0;
      retire_o        <= 1'b0;
      if (cycle_end) begin
        retire_o      <= 1'b1;
        flush_cycle_o <= next_flushing;
        if (writes_file) begin
          file_wr_o    <= 1'b1;
          file_wdata_o <= result;
          // Timer zero count written: clear prescaler if it owns it
          prescaler_clr_o <= (file_sel == `TIMER_ZERO_ADDR) &&
                             prescaler_on_timer_i;
        end
        if (writes_acc) begin
          acc_wr_o    <= 1'b1;
          acc_wdata_o <= (iclass == `CLS_LIT) ? lit8 :
                         (clr_acc ? 8'h00 : result);
        end
        if (!flushing && is_jump) begin
          pc_load_o   <= 1'b1;
          pc_target_o <= lit11;
        end
        if (!flushing && (is_return || is_retlw)) begin
          pc_return_o <= 1'b1;
        end
        if (!flushing && (is_jump || iclass == `CLS_LIT)) begin
          lit_valid_o <= 1'b1;
          lit_o       <= is_jump ? lit11 : {3'h0, lit8};
        end
      end
    end
  end

endmodule // instr_word_decode_timing

/* File: decode_monitor.sv */
// Port-level timing checker for the instruction decoder
`timescale 1ns/1ps
module decode_monitor #(
  parameter FILE_AW = 7
) (
  // Clock and reset
  input wire               sys_clk_i,
  input wire               arst_n_i,
  // Watched ports
  input wire               fetch_take_o,
  input wire               file_rd_o,
  input wire               file_wr_o,
  input wire [FILE_AW-1:0] file_addr_o,
  input wire               acc_wr_o,
  input wire               prescaler_clr_o,
  input wire               prescaler_on_timer_i,
  input wire               pc_load_o,
  input wire               retire_o
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  take_period_a: assert property (
    fetch_take_o |=> !fetch_take_o [*3] ##1 fetch_take_o)
    else $error("fetch take not every fourth clock");
  retire_period_a: assert property (
    retire_o |=> !retire_o [*3] ##1 retire_o)
    else $error("retire not once per four clocks");
  read_phase_a: assert property (
    file_rd_o |-> ##2 fetch_take_o)
    else $error("operand read off its phase");
  write_read_a: assert property (
    file_wr_o |-> $past(file_rd_o, 3)
      && $stable(file_addr_o))
    else $error("file write without operand read");
  one_target_a: assert property (
    !(acc_wr_o && file_wr_o))
    else $error("result sent to two places");
  write_retire_a: assert property (
    (acc_wr_o || file_wr_o) |-> retire_o)
    else $error("result stored outside retire");
  presc_clr_a: assert property (
    prescaler_clr_o |-> file_wr_o && file_addr_o == 7'h01)
    else $error("prescaler clear without timer write");
  presc_need_a: assert property (
    file_wr_o && file_addr_o == 7'h01 && prescaler_on_timer_i
      |-> prescaler_clr_o)
    else $error("timer write left prescaler");
  flush_quiet_a: assert property (
    pc_load_o |=> (!acc_wr_o && !file_wr_o && !pc_load_o) [*4])
    else $error("flushed word had an effect");
endmodule // decode_monitor

bind instr_word_decode_timing decode_monitor #(.FILE_AW(FILE_AW))
  i_decode_monitor (.sys_clk_i, .arst_n_i, .fetch_take_o, .file_rd_o,
  .file_wr_o, .file_addr_o, .acc_wr_o, .prescaler_clr_o,
  .prescaler_on_timer_i, .pc_load_o, .retire_o);

/* File: prog_mem_model.sv */
// Program memory model feeding instruction words
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  // Fetch side
  input  wire        fetch_take_i,
  input  wire        pc_load_i,
  input  wire [10:0] pc_target_i,
  output wire [13:0] word_o
);
  reg [13:0] mem [0:31];
  reg [4:0]  pc;
  integer    i;

  // Don't-care bits zero except word 16, set on purpose
  initial begin
    for (i = 0; i < 32; i = i + 1) mem[i] = 14'h0000;
    mem[1]  = 14'h07FF;
    mem[3]  = 14'h077F;
    mem[5]  = 14'h0085;
    mem[7]  = 14'h1790;
    mem[9]  = 14'h0886;
    mem[11] = 14'h0181;
    mem[13] = 14'h2810;
    mem[14] = 14'h30EE;
    mem[16] = 14'h335A;
  end

  // Inverse outside take so a stale sample never matches
  assign word_o = fetch_take_i ? mem[pc] : ~mem[pc];

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pc <= 5'h00;
    else if (pc_load_i) pc <= pc_target_i[4:0];
    else if (fetch_take_i) pc <= pc + 5'h01;
  end
endmodule // prog_mem_model

/* File: instr_word_decode_timing_tb.sv */
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`include "instr_decode_defines.vh"
module instr_word_decode_timing_tb;
  reg clk = 1'b0, rst_n = 1'b0, port = 1'b0, presc = 1'b1;
  reg  [7:0] rdata = 8'h12, pins = 8'h00, acc = 8'h34;
  wire [`IW_WIDTH-1:0] word;
  wire take, rd, wr, awr, pclr, pcl, pret, litv, fl, ret;
  wire [6:0] addr;
  wire [7:0] wdata, adata;
  wire [10:0] pct, lit;
  integer num_errors = 0, comparisons = 0, cyc = 0, t0, dt;
  reg rd_seen, fl_seen, pc_seen;
  reg [6:0] rd_addr;
  reg [10:0] pc_got;

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  prog_mem_model i_prog_mem_model (.sys_clk_i(clk), .arst_n_i(rst_n),
    .fetch_take_i(take), .pc_load_i(pcl), .pc_target_i(pct),
    .word_o(word));

  instr_word_decode_timing i_instr_word_decode_timing (
    .sys_clk_i(clk), .arst_n_i(rst_n), .fetch_word_i(word),
    .fetch_take_o(take), .file_rdata_i(rdata), .file_is_port_i(port),
    .port_pins_i(pins), .prescaler_on_timer_i(presc), .acc_i(acc),
    .carry_i(1'b0), .file_addr_o(addr), .file_rd_o(rd),
    .file_wr_o(wr), .file_wdata_o(wdata), .acc_wr_o(awr),
    .acc_wdata_o(adata), .prescaler_clr_o(pclr), .pc_load_o(pcl),
    .pc_target_o(pct), .pc_return_o(pret), .lit_valid_o(litv),
    .lit_o(lit), .flush_cycle_o(fl), .retire_o(ret));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input [63:0] name, input [15:0] exp, input [15:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s exp %h got %h", name, exp, got);
      end
    end
  endtask

  // Bounded wait for the next result strobe, logging side events
  task wait_wr;
    integer n;
    begin
      rd_seen = 1'b0; fl_seen = 1'b0; pc_seen = 1'b0; n = 0;
      @(negedge clk);
      while ((awr !== 1'b1) && (wr !== 1'b1) && n < 60) begin
        if (rd === 1'b1) begin rd_seen = 1'b1; rd_addr = addr; end
        if (fl === 1'b1) fl_seen = 1'b1;
        if (pcl === 1'b1) begin pc_seen = 1'b1; pc_got = pct; t0 = cyc; end
        n = n + 1;
        @(negedge clk);
      end
      if (n == 60) begin
        num_errors = num_errors + 1;
        $display("MISMATCH strobe exp 1 got 0");
        tally_and_finish;
      end
    end
  endtask

  task set_in(input [7:0] r, input [7:0] a, input p, input [7:0] pn);
    begin
      @(posedge clk);
      rdata <= r; acc <= a; port <= p; pins <= pn;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_byte_file;
    begin
      wait_wr;
      chk("fwr", 16'h1, {15'h0, wr});
      chk("faddr", 16'h7F, {9'h0, addr});
      chk("fdata", 16'h46, {8'h0, wdata});
      chk("rd", 16'h0FF, {8'h0, rd_seen, rd_addr});
      $display("byte to file done");
    end
  endtask

  task t_byte_acc;
    begin
      set_in(8'h12, 8'h34, 1'b0, 8'h00);
      wait_wr;
      chk("awr", 16'h1, {15'h0, awr});
      chk("adata", 16'h46, {8'h0, adata});
      $display("byte to acc done");
    end
  endtask

  task t_pure_write;
    begin
      set_in(8'hA5, 8'h3C, 1'b0, 8'h00);
      wait_wr;
      chk("rd", 16'h085, {8'h0, rd_seen, rd_addr});
      chk("fdata", 16'h3C, {8'h0, wdata});
      $display("pure write done");
    end
  endtask

  task t_bit_set;
    begin
      set_in(8'h00, 8'hFF, 1'b0, 8'h00);
      wait_wr;
      chk("baddr", 16'h10, {9'h0, addr});
      chk("bdata", 16'h80, {8'h0, wdata});
      $display("bit set done");
    end
  endtask

  task t_port_read;
    begin
      set_in(8'hF0, 8'h00, 1'b1, 8'h0F);
      wait_wr;
      chk("pdata", 16'h0F, {8'h0, wdata});
      $display("port read done");
    end
  endtask

  task t_timer_clr;
    begin
      set_in(8'h77, 8'h00, 1'b0, 8'h00);
      wait_wr;
      chk("tclr", 16'h081, {8'h0, pclr, addr});
      chk("tdata", 16'h00, {8'h0, wdata});
      $display("timer clear done");
    end
  endtask

  task t_goto_flush;
    begin
      set_in(8'h00, 8'h00, 1'b0, 8'h00);
      wait_wr;
      dt = cyc - t0;
      chk("jump", 16'h810, {4'h0, pc_seen, pc_got});
      chk("flush", 16'h1, {15'h0, fl_seen});
      chk("lit", 16'h5A, {8'h0, adata});
      chk("lit11", 16'h05A, {5'h0, lit});
      chk("litv", 16'h1, {15'h0, litv});
      chk("retire", 16'h1, {15'h0, ret});
      chk("pret", 16'h0, {15'h0, pret});
      chk("gap", 16'h8, dt[15:0]);
      $display("jump flush done");
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_byte_file;
    t_byte_acc;
    t_pure_write;
    t_bit_set;
    t_port_read;
    t_timer_clr;
    t_goto_flush;
    repeat (8) @(posedge clk);
    tally_and_finish;
  end
endmodule // instr_word_decode_timing_tb
